// ### verilog/dma_transfer_sequencer_defines.vh
`ifndef DMA_TRANSFER_SEQUENCER_DEFINES_VH
`define DMA_TRANSFER_SEQUENCER_DEFINES_VH
// =====================================================================
// Register map (byte offsets on paddr[7:0])
`define OFS_MASTER        8'h40
`define OFS_INT_STATUS    8'h44
`define OFS_INT_MASK      8'h48
// Per channel block: channel in paddr[5:4], word in paddr[3:2]
`define WORD_SOURCE       2'h0
`define WORD_DEST         2'h1
`define WORD_COUNT        2'h2
`define WORD_CONTROL      2'h3
// =====================================================================
// Channel control field positions
`define CC_ENABLE         0
`define CC_BURST          1
`define CC_INDIRECT       2
`define CC_REQ_LSB        3
`define CC_REQ_MSB        7
`define CC_SIZE_LSB       8
`define CC_SIZE_MSB       9
`define CC_NARROW         10
`define CC_WIDTH          11
// Master register field positions
`define MR_ENABLE         0
`define MR_NMI            1
`define MR_ADDR_ERR       2
// =====================================================================
// Request select codes
`define REQ_AUTO          5'h00
`define REQ_EVENT_FIRST   5'h11
`define REQ_EVENT_LAST    5'h1C
// Transfer unit size codes (also driven on busSize)
`define SIZE8             2'h0
`define SIZE16            2'h1
`define SIZE32            2'h2
// Count width, reset value and half-cycle address step
`define COUNT_WIDTH       24
`define RESET_WORD        32'h0000_0000
`define HALF_STEP         32'h0000_0002
// =====================================================================
// Sequencer states
`define ST_IDLE           3'h0
`define ST_GRANT          3'h1
`define ST_POINTER        3'h2
`define ST_NOP            3'h3
`define ST_READ           3'h4
`define ST_WRITE          3'h5
`define ST_NEXT           3'h6
`endif

// ### verilog/dma_transfer_sequencer.v
`timescale 1ns/1ns
`include "dma_transfer_sequencer_defines.vh"

module dma_transfer_sequencer (
   input  wire        clk,          // System clock
   input  wire        rstn,         // Synchronous reset, low
   input  wire        psel,         // APB select
   input  wire        penable,      // APB enable
   input  wire        pwrite,       // APB direction
   input  wire [7:0]  paddr,        // APB byte address
   input  wire [31:0] pwdata,       // APB write data
   output reg  [31:0] prdata,       // APB read data
   output reg         pready,       // APB ready
   output reg         pslverr,      // APB error, unmapped
   input  wire [11:0] timerEvents,  // Capture 0A-0D, match 6A-6D, 7A-7D
   input  wire        nmiEvent,     // NMI pulse
   input  wire        addrErrEvent, // Address error pulse
   output reg         busReq,       // System bus request
   input  wire        busGrant,     // System bus granted
   output reg         busValid,     // Bus cycle active
   output reg         busWrite,     // Bus cycle direction
   output reg  [31:0] busAddr,      // Bus cycle address
   output reg  [1:0]  busSize,      // Bus cycle size code
   output reg  [31:0] busWdata,     // Bus write data
   input  wire [31:0] busRdata,     // Bus read data
   input  wire        busReady,     // Bus cycle done
   output reg         irq           // Level interrupt
);

   // ==================================================================
   // Storage
   reg [31:0]              sourceAddr [0:3];
   reg [31:0]              destAddr   [0:3];
   reg [`COUNT_WIDTH-1:0]  transferCount [0:3];
   reg [`CC_WIDTH-1:0]     channelControl [0:3];
   reg [3:0]               pending;         // Latched timer requests
   reg [3:0]               transferEndFlag; // Sticky, also irq status
   reg [3:0]               intMask;
   reg                     masterEnable;
   reg                     nmiFlag;
   reg                     addressErrorFlag;
   reg [2:0]               state;
   reg [1:0]               curCh;
   reg                     half;            // Second half of split cycle
   reg [31:0]              pointer;         // Indirect address buffer
   reg [31:0]              dataBuf;         // Transfer data buffer
   integer                 i, j;

   // ==================================================================
   // Helpers
   // fixed priority
   function [1:0] pickWinner;
      input [3:0] req;
      begin
         pickWinner = req[0] ? 2'h0 : req[1] ? 2'h1 : req[2] ? 2'h2 : 2'h3;
      end
   endfunction

   function eventHit;
      input [4:0]  code;
      input [11:0] ev;
      reg   [4:0]  idx;
      begin
         idx = code - `REQ_EVENT_FIRST;
         eventHit = (code >= `REQ_EVENT_FIRST && code <= `REQ_EVENT_LAST) ?
                    ev[idx[3:0]] : 1'b0;
      end
   endfunction

   // ==================================================================
   // Eligibility per channel
   reg [3:0] eligible;
   always @* begin
      for (j = 0; j < 4; j = j + 1) begin
         eligible[j] = channelControl[j][`CC_ENABLE] & masterEnable &
            ~transferEndFlag[j] & ~nmiFlag & ~addressErrorFlag &
            (transferCount[j] != {`COUNT_WIDTH{1'b0}}) &
            ((channelControl[j][`CC_REQ_MSB:`CC_REQ_LSB] == `REQ_AUTO)
             | pending[j]);
      end
   end

   // Current channel decode
   wire [`CC_WIDTH-1:0] cc       = channelControl[curCh];
   wire [1:0]           unitSize = cc[`CC_SIZE_MSB:`CC_SIZE_LSB];
   wire                 narrow   = cc[`CC_NARROW];
   // 32-bit units through 16-bit space split in two
   wire                 split    = narrow & (unitSize == `SIZE32);
   wire [1:0]           cycSize  = split ? `SIZE16 : unitSize;
   wire [31:0]          readBase = cc[`CC_INDIRECT] ? pointer
                                                    : sourceAddr[curCh];
   wire [1:0]           winner   = pickWinner(eligible);
   wire [`COUNT_WIDTH-1:0] countLeft = transferCount[curCh] -
                                       {{(`COUNT_WIDTH-1){1'b0}}, 1'b1};

   // ==================================================================
   // APB read mux
   wire       chRegion = (paddr[7:6] == 2'h0);
   wire [1:0] regCh    = paddr[5:4];
   reg [31:0] readValue;
   reg        mapped;
   always @* begin
      readValue = `RESET_WORD;
      mapped    = 1'b1;
      if (paddr[1:0] != 2'h0)
         mapped = 1'b0;
      else if (chRegion) begin
         case (paddr[3:2])
            `WORD_SOURCE: readValue = sourceAddr[regCh];
            `WORD_DEST:   readValue = destAddr[regCh];
            `WORD_COUNT:  readValue = {8'h00, transferCount[regCh]};
            default:      readValue = {20'h0_0000, transferEndFlag[regCh],
                                       channelControl[regCh]};
         endcase
      end else if (paddr == `OFS_MASTER)
         readValue = {29'h0000_0000, addressErrorFlag, nmiFlag,
                      masterEnable};
      else if (paddr == `OFS_INT_STATUS)
         readValue = {28'h000_0000, transferEndFlag};
      else if (paddr == `OFS_INT_MASK)
         readValue = {28'h000_0000, intMask};
      else
         mapped = 1'b0;
   end

   wire apbWrite = psel & penable & pready & pwrite & mapped;

   // ==================================================================
   // Bus cycle launch, address held until busReady
   task issue;
      input        wr;
      input [31:0] a;
      input [1:0]  sz;
      input [31:0] wd;
      begin
         busValid <= 1'b1;
         busWrite <= wr;
         busAddr  <= a;
         busSize  <= sz;
         busWdata <= wd;
      end
   endtask

   // Begin one transfer unit on channel w, bus already owned
   task startUnit;
      input [1:0] w;
      begin
         curCh      <= w;
         half       <= 1'b0;
         pending[w] <= 1'b0;
         // pointer fetch first, channel 3 only
         if (channelControl[w][`CC_INDIRECT]) begin
            state <= `ST_POINTER;
            // 16-bit space fetches pointer in halves
            issue(1'b0, sourceAddr[w],
                  channelControl[w][`CC_NARROW] ? `SIZE16 : `SIZE32,
                  `RESET_WORD);
         end else begin
            state <= `ST_READ;
            issue(1'b0, sourceAddr[w],
                  (channelControl[w][`CC_NARROW] &&
                   channelControl[w][`CC_SIZE_MSB:`CC_SIZE_LSB] ==
                   `SIZE32) ? `SIZE16 :
                  channelControl[w][`CC_SIZE_MSB:`CC_SIZE_LSB],
                  `RESET_WORD);
         end
      end
   endtask

   // ==================================================================
   // Registers and transfer sequencer
   always @(posedge clk) begin
      if (!rstn) begin
         for (i = 0; i < 4; i = i + 1) begin
            sourceAddr[i]     <= `RESET_WORD;
            destAddr[i]       <= `RESET_WORD;
            transferCount[i]  <= {`COUNT_WIDTH{1'b0}};
            channelControl[i] <= {`CC_WIDTH{1'b0}};
         end
         pending          <= 4'h0;
         transferEndFlag  <= 4'h0;
         intMask          <= 4'h0;
         masterEnable     <= 1'b0;
         nmiFlag          <= 1'b0;
         addressErrorFlag <= 1'b0;
         state            <= `ST_IDLE;
         curCh            <= 2'h0;
         half             <= 1'b0;
         pointer          <= `RESET_WORD;
         dataBuf          <= `RESET_WORD;
         prdata           <= `RESET_WORD;
         pready           <= 1'b0;
         pslverr          <= 1'b0;
         busReq           <= 1'b0;
         busValid         <= 1'b0;
         busWrite         <= 1'b0;
         busAddr          <= `RESET_WORD;
         busSize          <= `SIZE8;
         busWdata         <= `RESET_WORD;
         irq              <= 1'b0;
      end else begin
         // APB slave, one wait-free access phase
         pready  <= psel & ~penable;
         // Error stands one cycle with pready, never lingers after it
         pslverr <= psel & ~penable & ~mapped;
         if (psel & ~penable)
            prdata <= readValue;
         // addresses taken as written, any category
         if (apbWrite && chRegion) begin
            case (paddr[3:2])
               `WORD_SOURCE: sourceAddr[regCh] <= pwdata;
               `WORD_DEST:   destAddr[regCh]   <= pwdata;
               `WORD_COUNT:  transferCount[regCh] <=
                                pwdata[`COUNT_WIDTH-1:0];
               // indirect bit sticks only on channel 3
               default: channelControl[regCh] <=
                  {pwdata[`CC_WIDTH-1:`CC_INDIRECT+1],
                   pwdata[`CC_INDIRECT] & (regCh == 2'h3),
                   pwdata[`CC_INDIRECT-1:0]};
            endcase
         end
         if (apbWrite && paddr == `OFS_MASTER) begin
            masterEnable <= pwdata[`MR_ENABLE];
            if (pwdata[`MR_NMI])
               nmiFlag <= 1'b0;
            if (pwdata[`MR_ADDR_ERR])
               addressErrorFlag <= 1'b0;
         end
         if (apbWrite && paddr == `OFS_INT_STATUS)
            transferEndFlag <= transferEndFlag & ~pwdata[3:0];
         if (apbWrite && paddr == `OFS_INT_MASK)
            intMask <= pwdata[3:0];

         // Sequencer; flags only stop work at unit boundaries
         case (state)
            `ST_IDLE: begin
               if (|eligible) begin
                  busReq <= 1'b1;
                  state  <= `ST_GRANT;
               end
            end
            `ST_GRANT: begin
               if (busGrant) begin
                  if (|eligible)
                     startUnit(winner);
                  else begin
                     busReq <= 1'b0;
                     state  <= `ST_IDLE;
                  end
               end
            end
            `ST_POINTER: begin
               if (busValid && busReady) begin
                  if (narrow && !half) begin
                     pointer[31:16] <= busRdata[15:0];
                     half           <= 1'b1;
                     issue(1'b0, sourceAddr[curCh] + `HALF_STEP,
                           `SIZE16, `RESET_WORD);
                  end else begin
                     pointer  <= narrow ? {pointer[31:16], busRdata[15:0]}
                                        : busRdata;
                     half     <= 1'b0;
                     busValid <= 1'b0;
                     state    <= `ST_NOP;
                  end
               end
            end
            `ST_NOP: begin
               // data read at the fetched pointer
               state <= `ST_READ;
               issue(1'b0, pointer, cycSize, `RESET_WORD);
            end
            `ST_READ: begin
               if (busValid && busReady) begin
                  if (split && !half) begin
                     dataBuf[31:16] <= busRdata[15:0];
                     half           <= 1'b1;
                     issue(1'b0, readBase + `HALF_STEP, `SIZE16,
                           `RESET_WORD);
                  end else begin
                     dataBuf <= split ? {dataBuf[31:16], busRdata[15:0]}
                                      : busRdata;
                     half    <= 1'b0;
                     state   <= `ST_WRITE;
                     issue(1'b1, destAddr[curCh], cycSize,
                           split ? {16'h0000, dataBuf[31:16]} : busRdata);
                  end
               end
            end
            `ST_WRITE: begin
               if (busValid && busReady) begin
                  if (split && !half) begin
                     half <= 1'b1;
                     issue(1'b1, destAddr[curCh] + `HALF_STEP, `SIZE16,
                           {16'h0000, dataBuf[15:0]});
                  end else begin
                     busValid <= 1'b0;
                     half     <= 1'b0;
                     transferCount[curCh] <= countLeft;
                     if (countLeft == {`COUNT_WIDTH{1'b0}})
                        transferEndFlag[curCh] <= 1'b1;
                     state <= `ST_NEXT;
                  end
               end
            end
            `ST_NEXT: begin
               // burst keeps bus while channel eligible
               // winner re-picked at each unit boundary
               if (cc[`CC_BURST] && eligible[curCh])
                  startUnit(winner);
               else begin
                  busReq <= 1'b0;
                  state  <= `ST_IDLE;
               end
            end
            default: begin
               busReq   <= 1'b0;
               busValid <= 1'b0;
               state    <= `ST_IDLE;
            end
         endcase

         // Hardware sets last, so they win over same-cycle clears
         for (i = 0; i < 4; i = i + 1) begin
            if (eventHit(channelControl[i][`CC_REQ_MSB:`CC_REQ_LSB],
                         timerEvents))
               pending[i] <= 1'b1;
         end
         if (nmiEvent)
            nmiFlag <= 1'b1;
         if (addrErrEvent)
            addressErrorFlag <= 1'b1;
         irq <= |(transferEndFlag & intMask);
      end
   end

endmodule // dma_transfer_sequencer

// ### dv/dma_transfer_sequencer_assertions.sv
`timescale 1ns/1ns
// ==========================
// Port checker
module dma_transfer_sequencer_assertions (
   input wire        clk,      // System clock
   input wire        rstn,     // Reset, low
   input wire        psel,     // APB select
   input wire        penable,  // APB enable
   input wire        pready,   // APB ready
   input wire        pslverr,  // APB error
   input wire        busReq,   // Bus request
   input wire        busGrant, // Bus grant
   input wire        busValid, // Cycle active
   input wire        busWrite, // Cycle direction
   input wire [31:0] busAddr,  // Cycle address
   input wire        busReady  // Cycle done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_hold;
      busValid && !busReady |=> busValid && $stable(busAddr)
         && $stable(busWrite);
   endproperty
   a_hold: assert property (p_hold)
      else $error("bus cycle changed before ready");

   property p_first;
      $rose(busValid) |-> !busWrite;
   endproperty
   a_first: assert property (p_first)
      else $error("bus activity began with a write");

   // A read followed by a gap is the pointer fetch
   property p_nop;
      $fell(busValid) && !$past(busWrite) |=> busValid && !busWrite;
   endproperty
   a_nop: assert property (p_nop)
      else $error("idle gap after pointer read not one cycle");

   property p_owned;
      busValid |-> busReq;
   endproperty
   a_owned: assert property (p_owned)
      else $error("bus cycle without bus request");

   property p_grant;
      $rose(busValid) |-> $past(busGrant) && busReq;
   endproperty
   a_grant: assert property (p_grant)
      else $error("bus cycle without grant");

   property p_wr_end;
      busValid && busReady && busWrite |=> !busValid || busWrite;
   endproperty
   a_wr_end: assert property (p_wr_end)
      else $error("read issued right after a write");

   property p_apb;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_apb: assert property (p_apb)
      else $error("register access not answered in one cycle");

   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err)
      else $error("error without ready");
endmodule // dma_transfer_sequencer_assertions

bind dma_transfer_sequencer dma_transfer_sequencer_assertions u_chk (
   .clk, .rstn, .psel, .penable, .pready, .pslverr, .busReq, .busGrant,
   .busValid, .busWrite, .busAddr, .busReady);

// ### dv/bus_slave_model.sv
`timescale 1ns/1ns
// ==========================
// Shared system bus
module bus_slave_model (
   input  wire        clk,               // System clock
   input  wire        busReq,            // Engine wants bus
   input  wire        busValid,          // Cycle active
   input  wire [31:0] busAddr,           // Cycle address
   input  wire [3:0]  waitCycles,        // Extra wait states
   output reg         busGrant = 1'b0,   // Bus granted
   output reg         busReady = 1'b0,   // Cycle done
   output reg  [31:0] busRdata = 32'h0   // Read data
);
   reg [3:0] cnt = 4'h0;

   // Grant trails the request; read data is address plus a fixed step,
   // and flips when idle so stale data never looks right
   always @(posedge clk) begin
      busGrant <= busReq;
      if (busValid && !busReady && cnt >= waitCycles) begin
         busReady <= 1'b1;
         busRdata <= busAddr + 32'h0000_1000;
         cnt      <= 4'h0;
      end else begin
         busReady <= 1'b0;
         busRdata <= ~busRdata;
         if (busValid && !busReady)
            cnt <= cnt + 4'h1;
      end
   end
endmodule // bus_slave_model

// ### dv/tb_dma_transfer_sequencer.sv
`timescale 1ns/1ns
module tb_dma_transfer_sequencer;
   logic        clk, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        nmiEvent = 0, addrErrEvent = 0, err, rq = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, q;
   logic [11:0] timerEvents = 0;
   logic [3:0]  waitCycles = 0;
   wire  [31:0] prdata, busAddr, busWdata, busRdata;
   wire  [1:0]  busSize;
   wire         pready, pslverr, busReq, busGrant, busValid;
   wire         busWrite, busReady, irq;
   int          bad_count = 0, total_checks = 0, reqFalls = 0;
   logic [31:0] logA[$], logD[$];
   logic        logW[$];
   logic [1:0]  logS[$];

   dma_transfer_sequencer dut (.clk, .rstn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .timerEvents,
      .nmiEvent, .addrErrEvent, .busReq, .busGrant, .busValid, .busWrite,
      .busAddr, .busSize, .busWdata, .busRdata, .busReady, .irq);
   bus_slave_model peer (.clk, .busReq, .busValid, .busAddr, .waitCycles,
      .busGrant, .busReady, .busRdata);

   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end

   // Log finished bus cycles mid-cycle, clear of edge updates
   always @(negedge clk) begin
      if (busValid === 1'b1 && busReady === 1'b1) begin
         logA.push_back(busAddr);
         logD.push_back(busWdata);
         logW.push_back(busWrite);
         logS.push_back(busSize);
      end
      if (busReq === 1'b0 && rq === 1'b1)
         reqFalls++;
      rq = busReq;
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask

   // One APB transfer; waits on pready, no fixed latency assumed
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // Ready and read data are taken at a rising edge only
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      chk("pready", 1, pready);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task setup(input int c, input logic [31:0] s, d, n, t);
      logic [7:0] b;
      b = 8'(c * 16);
      apb(1, 8'h44, 32'h0000_000F);
      apb(1, b, s);
      apb(1, b + 8'h04, d);
      // Control before count, so an old auto code cannot start early
      apb(1, b + 8'h0C, t);
      apb(1, b + 8'h08, n);
   endtask

   task clr;
      logA.delete();
      logD.delete();
      logW.delete();
      logS.delete();
      reqFalls = 0;
   endtask

   task wait_log(input int n);
      int k;
      k = 0;
      while (logA.size() < n && k < 500) begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      chk("bus cycles", n, logA.size());
   endtask

   task pulse(input int k);
      timerEvents <= 12'h001 << k;
      @(posedge clk);
      timerEvents <= 12'h000;
   endtask

   task t_regs;
      apb(1, 8'h2C, 32'h0000_0004);
      apb(0, 8'h2C, 0);
      chk("ch2 indirect", 0, q);
      apb(0, 8'h08, 0);
      chk("count reset", 0, q);
      apb(0, 8'h4C, 0);
      chk("unmapped err", 1, err);
      $display("test regs done");
   endtask

   task t_direct;
      clr;
      setup(0, 32'h0000_0100, 32'h0000_0200, 32'h0000_0002, 32'h0000_0201);
      wait_log(4);
      chk("src addr", 32'h0000_0100, logA[0]);
      chk("dst addr", 32'h0000_0200, logA[1]);
      chk("dst write", 1, logW[1]);
      chk("moved data", 32'h0000_1100, logD[1]);
      chk("unit size", 32'h0000_0002, logS[0]);
      chk("releases", 2, reqFalls);
      apb(0, 8'h0C, 0);
      chk("end flag", 1, q[11]);
      chk("irq masked", 0, irq);
      apb(1, 8'h48, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("irq raised", 1, irq);
      apb(1, 8'h44, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("irq cleared", 0, irq);
      $display("test direct done");
   endtask

   task t_burst;
      clr;
      setup(1, 32'h0000_0110, 32'h0000_0210, 32'h0000_0003, 32'h0000_0203);
      wait_log(6);
      chk("burst releases", 1, reqFalls);
      $display("test burst done");
   endtask

   task t_prio;
      apb(1, 8'h40, 0);
      setup(3, 32'h0000_0130, 32'h0000_0230, 32'h0000_0001, 32'h0000_0201);
      setup(2, 32'h0000_0120, 32'h0000_0220, 32'h0000_0001, 32'h0000_0201);
      setup(1, 32'h0000_0110, 32'h0000_0210, 32'h0000_0001, 32'h0000_0201);
      clr;
      apb(1, 8'h40, 32'h0000_0001);
      wait_log(6);
      chk("first", 32'h0000_0110, logA[0]);
      chk("second", 32'h0000_0120, logA[2]);
      chk("third", 32'h0000_0130, logA[4]);
      $display("test priority done");
   endtask

   // Timer codes on cycle steal; plain memory addresses only
   task t_timer;
      for (int i = 0; i < 12; i++) begin
         setup(0, 32'h0000_0140, 32'h0000_0240, 32'h0000_0001,
            32'h0000_0201 | (32'(i + 17) << 3));
         clr;
         pulse((i + 1) % 12);
         repeat (20) @(posedge clk);
         chk("other event", 0, logA.size());
         pulse(i);
         wait_log(2);
      end
      $display("test timer done");
   endtask

   task t_ind;
      logic [31:0] ea[6];
      ea = '{32'h0000_0100, 32'h0000_0102, 32'h1100_1102, 32'h1100_1104,
         32'h0000_0300, 32'h0000_0302};
      waitCycles <= 4'h2;
      clr;
      setup(3, 32'h0000_0100, 32'h0000_0300, 32'h0000_0001, 32'h0000_0605);
      wait_log(6);
      for (int i = 0; i < 6; i++) begin
         chk("ind addr", ea[i], logA[i]);
         chk("ind dir", i > 3, logW[i]);
      end
      chk("hi half", 32'h0000_2102, logD[4] & 32'h0000_FFFF);
      chk("lo half", 32'h0000_2104, logD[5] & 32'h0000_FFFF);
      chk("half size", 32'h0000_0001, logS[0]);
      waitCycles <= 4'h0;
      $display("test indirect done");
   endtask

   task t_flags;
      nmiEvent <= 1;
      addrErrEvent <= 1;
      @(posedge clk);
      nmiEvent <= 0;
      addrErrEvent <= 0;
      setup(0, 32'h0000_0150, 32'h0000_0250, 32'h0000_0001, 32'h0000_0201);
      clr;
      repeat (30) @(posedge clk);
      chk("blocked", 0, logA.size());
      apb(0, 8'h40, 0);
      chk("flags", 32'h0000_0007, q);
      apb(1, 8'h40, 32'h0000_0007);
      wait_log(2);
      $display("test flags done");
   endtask

   task results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog, far beyond the thousand or so cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      results;
   end

   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      t_regs;
      apb(1, 8'h40, 32'h0000_0001);
      t_direct;
      t_burst;
      t_prio;
      t_timer;
      t_ind;
      t_flags;
      results;
   end
endmodule // tb_dma_transfer_sequencer
